// [hw/rhtc_pkg.sv]
// Purpose: constants for the row repair and training host controller
// Assumes: 250 MHz command clock, one command per clock
// Notes: device timings are plain defaults, retune per speed grade
package rhtc_pkg;
  localparam int CLK_PS = 4000;
  // software register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TRR_CFG_OFS = 8'h04;
  localparam logic [7:0] CAPS_OFS = 8'h08;
  localparam logic [7:0] TRN_CFG_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;
  // control register fields
  localparam int CTRL_TRR_BIT = 0;
  localparam int CTRL_PPR_BIT = 1;
  localparam int CTRL_TRN_BIT = 2;
  localparam int CTRL_ABT_BIT = 3;
  localparam logic [7:0] PPR_KEY = 8'hA5;
  localparam int PPR_KEY_LSB = 24;
  // device mode register addresses and bits
  localparam logic [5:0] ROW_HAMMER_CTRL_REG = 6'h18;
  localparam logic [5:0] REFRESH_REPAIR_REG = 6'h04;
  localparam logic [5:0] TRAINING_CTRL_REG = 6'h0D;
  localparam logic [5:0] PATTERN_LOW_REG = 6'h20;
  localparam logic [5:0] PATTERN_HIGH_REG = 6'h28;
  localparam int TRR_EN_BIT = 7;
  localparam int UNLIM_BIT = 3;
  localparam logic [7:0] REPAIR_ON_OP = 8'h10;
  localparam logic [7:0] TRN_ON_OP = 8'h02;
  localparam logic [7:0] OP_ZERO = 8'h00;
  // timings in their own units
  localparam int MRD_NS = 14;
  localparam int RAS_NS = 42;
  localparam int RP_NS = 18;
  localparam int SDO_NS = 20;
  localparam int REPAIR_EXIT_NS = 15;
  localparam int REPAIR_PROG_MS = 1000;
  localparam int REPAIR_SETTLE_US = 50;
  localparam int CCD_CYC = 8;
  // least times rounded up to whole cycles
  localparam int MRD_CYC = (MRD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RAS_CYC = (RAS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RAS15_CYC = (RAS_NS * 1500 + CLK_PS - 1) / CLK_PS;
  localparam int RP_CYC = (RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SDO_CYC = (SDO_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int EXIT_CYC = (REPAIR_EXIT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int HOLD_CYC = RAS15_CYC + RP_CYC;
  localparam int PROG_CYC = REPAIR_PROG_MS * (1000000000 / CLK_PS);
  localparam int SETTLE_CYC = REPAIR_SETTLE_US * (1000000 / CLK_PS);
  typedef enum logic [2:0] {
    CMD_MRW, CMD_ACT, CMD_PRE, CMD_PREA, CMD_MPC_RDC, CMD_CAS2
  } rhtc_cmd_type;
endpackage

// [hw/rhtc_ctrl.sv]
// What this block does
// - enable bit 7 of row hammer control starts targeted refresh; bits 6:4 pick bank.
// - unlimited activate limit (low bits 000, bit 3 set) skips targeted refresh.
// - enter targeted refresh from idle only; no mode writes except abort.
// - completed mode may be exited by clearing enable; bank field ignored.
// - three activates and three precharges of the hammered bank complete it.
// - after enabling write and delay, only activate and precharge go out.
// - other banks stay idle 1.5 row-active plus one precharge time from first activate.
// - precharge 1.5 or 1 row-active after activate; activate one precharge time later.
// - recovery clears enable, sends three spaced precharges, then reruns the sequence.
// - no refresh or self-refresh entry while targeted refresh runs.
// - targeted activates count toward four-activate window; normal timings stay.
// - repair support read from repair resource register; one row per bank.
// - repair: precharge all, set bit 4, activate, precharge, clear bit 4.
// - no commands at all for the whole repair programming time.
// - wait 15 ns after repair precharge, 50 us after leaving repair.
// - after repair a full reset is needed; contents may be lost.
// - each calibration command plus CAS-2 returns low then high pattern.
// - training sends only calibration commands, column delay apart, operands low, BL16; the first calibration command goes out with operand TRN_ON_OP.
//
// Purpose: host sequencer for targeted refresh, spare-row repair, preamble training
// Assumes: one command slot per clock; scheduler honours the hold outputs
// Notes: long repair counts are parameters so simulation can shorten them
`timescale 1ns/1ns
`default_nettype none
module rhtc_ctrl #(
  parameter int PROG_CYCLES = rhtc_pkg::PROG_CYC,
  parameter int SETTLE_CYCLES = rhtc_pkg::SETTLE_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic cmd_valid_out,
  output logic [2:0] cmd_code_out,
  output logic [2:0] cmd_bank_out,
  output logic [15:0] cmd_row_out,
  output logic [5:0] cmd_mr_addr_out,
  output logic [7:0] cmd_op_out,
  output logic refresh_hold_out,
  output logic bank_hold_out
);
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE, S_T_MRW, S_T_ACT, S_T_PRE, S_T_END, S_A_MRW, S_A_PRE,
    S_P_PREA, S_P_ON, S_P_ACT, S_P_PRE, S_P_OFF, S_P_END,
    S_N_LOW, S_N_HIGH, S_N_ON, S_N_MPC, S_N_CAS, S_N_OFF, S_N_END
  } rhtc_state_type;

  rhtc_state_type state_r, state_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [2:0] bank_r, bank_nxt;
  logic [15:0] row_r, row_nxt;
  logic [7:0] caps_r, caps_nxt;
  logic [7:0] res_r, res_nxt;
  logic [23:0] trn_r, trn_nxt;
  logic [4:0] flag_r, flag_nxt;
  logic cv_r, cv_nxt;
  logic [2:0] cc_r, cc_nxt;
  logic [7:0] op_r, op_nxt;
  logic [5:0] ma_r, ma_nxt;
  logic [15:0] crow_r, crow_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic go, trr_st, abt, wr_ctrl, unlim, in_trr, in_ppr;
  logic [7:0] last;

  // ---------------------------------------------------------------
  // register port and sequencer next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    hold_nxt = (hold_r != 16'h0000) ? hold_r - 16'h0001 : hold_r;
    cnt_nxt = cnt_r;
    bank_nxt = bank_r;
    row_nxt = row_r;
    caps_nxt = caps_r;
    res_nxt = res_r;
    trn_nxt = trn_r;
    flag_nxt = flag_r;
    cv_nxt = 1'b0;
    cc_nxt = cc_r;
    op_nxt = op_r;
    ma_nxt = ma_r;
    crow_nxt = crow_r;
    rd_nxt = 32'h0000_0000;
    wr_ctrl = wr_in && (addr_in == rhtc_pkg::CTRL_OFS);
    abt = wr_ctrl && wdata_in[rhtc_pkg::CTRL_ABT_BIT];
    unlim = (caps_r[2:0] == 3'h0) && caps_r[rhtc_pkg::UNLIM_BIT];
    in_trr = (state_r >= S_T_MRW) && (state_r <= S_A_PRE);
    in_ppr = (state_r >= S_P_PREA) && (state_r <= S_P_END);
    trr_st = (state_r >= S_T_ACT) && (state_r <= S_T_PRE);
    go = (tmr_r == 32'h0000_0000);
    last = (trn_r[23:16] == 8'h00) ? 8'h00 : trn_r[23:16] - 8'h01;
    if (wr_in && state_r == S_IDLE)
    begin
      unique case (addr_in)
        rhtc_pkg::TRR_CFG_OFS:
        begin
          bank_nxt = wdata_in[2:0];
          row_nxt = wdata_in[31:16];
        end
        rhtc_pkg::CAPS_OFS:
        begin
          caps_nxt = wdata_in[7:0];
          res_nxt = wdata_in[15:8];
        end
        rhtc_pkg::TRN_CFG_OFS: trn_nxt = wdata_in[23:0];
        default: ;
      endcase
    end
    if (wr_in && addr_in == rhtc_pkg::STAT_OFS)
      flag_nxt = flag_r & ~wdata_in[4:0];
    if (rd_in)
    begin
      unique case (addr_in)
        rhtc_pkg::TRR_CFG_OFS: rd_nxt = {row_r, 13'h0000, bank_r};
        rhtc_pkg::CAPS_OFS: rd_nxt = {16'h0000, res_r, caps_r};
        rhtc_pkg::TRN_CFG_OFS: rd_nxt = {8'h00, trn_r};
        rhtc_pkg::STAT_OFS: rd_nxt = {16'h0000, 3'h0, state_r, 2'h0,
          state_r != S_IDLE, flag_r};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
    if (!go)
      tmr_nxt = tmr_r - 32'h0000_0001;
    unique case (state_r)
      S_IDLE:
      begin
        cnt_nxt = 8'h00;
        if (wr_ctrl && wdata_in[rhtc_pkg::CTRL_TRR_BIT])
        begin
          if (unlim)
            flag_nxt[3] = 1'b1;
          else
            state_nxt = S_T_MRW;
        end
        else if (wr_ctrl && wdata_in[rhtc_pkg::CTRL_PPR_BIT])
        begin
          if (wdata_in[31:rhtc_pkg::PPR_KEY_LSB] != rhtc_pkg::PPR_KEY
              || !res_r[bank_r] || flag_r[1])
            flag_nxt[4] = 1'b1;
          else
            state_nxt = S_P_PREA;
        end
        else if (wr_ctrl && wdata_in[rhtc_pkg::CTRL_TRN_BIT])
          state_nxt = S_N_LOW;
      end
      S_T_MRW:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_MRW;
          ma_nxt = rhtc_pkg::ROW_HAMMER_CTRL_REG;
          op_nxt = {1'b1, bank_r, caps_r[3:0]};
          tmr_nxt = 32'(rhtc_pkg::MRD_CYC - 1);
          cnt_nxt = 8'h00;
          state_nxt = S_T_ACT;
        end
      S_T_ACT:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_ACT;
          crow_nxt = row_r;
          if (cnt_r == 8'h00)
          begin
            tmr_nxt = 32'(rhtc_pkg::RAS15_CYC - 1);
            hold_nxt = 16'(rhtc_pkg::HOLD_CYC);
          end
          else
            tmr_nxt = 32'(rhtc_pkg::RAS_CYC - 1);
          state_nxt = S_T_PRE;
        end
      S_T_PRE:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_PRE;
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r == 8'h02)
          begin
            tmr_nxt = 32'(rhtc_pkg::RP_CYC + rhtc_pkg::MRD_CYC - 1);
            state_nxt = S_T_END;
          end
          else
          begin
            tmr_nxt = 32'(rhtc_pkg::RP_CYC - 1);
            state_nxt = S_T_ACT;
          end
        end
      S_T_END:
        if (go)
        begin
          flag_nxt[0] = 1'b1;
          state_nxt = S_IDLE;
        end
      S_A_MRW:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_MRW;
          ma_nxt = rhtc_pkg::ROW_HAMMER_CTRL_REG;
          op_nxt = {1'b0, bank_r, caps_r[3:0]};
          tmr_nxt = 32'(rhtc_pkg::MRD_CYC - 1);
          cnt_nxt = 8'h00;
          state_nxt = S_A_PRE;
        end
      S_A_PRE:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_PRE;
          tmr_nxt = 32'(rhtc_pkg::RP_CYC - 1);
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r == 8'h02)
            state_nxt = S_T_MRW;
        end
      S_P_PREA:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_PREA;
          tmr_nxt = 32'(rhtc_pkg::RP_CYC - 1);
          state_nxt = S_P_ON;
        end
      S_P_ON:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_MRW;
          ma_nxt = rhtc_pkg::REFRESH_REPAIR_REG;
          op_nxt = rhtc_pkg::REPAIR_ON_OP;
          tmr_nxt = 32'(rhtc_pkg::MRD_CYC - 1);
          state_nxt = S_P_ACT;
        end
      S_P_ACT:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_ACT;
          crow_nxt = row_r;
          tmr_nxt = 32'(PROG_CYCLES - 1);
          state_nxt = S_P_PRE;
        end
      S_P_PRE:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_PRE;
          tmr_nxt = 32'(rhtc_pkg::EXIT_CYC - 1);
          state_nxt = S_P_OFF;
        end
      S_P_OFF:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_MRW;
          ma_nxt = rhtc_pkg::REFRESH_REPAIR_REG;
          op_nxt = rhtc_pkg::OP_ZERO;
          tmr_nxt = 32'(SETTLE_CYCLES - 1);
          state_nxt = S_P_END;
        end
      S_P_END:
        if (go)
        begin
          flag_nxt[1] = 1'b1;
          state_nxt = S_IDLE;
        end
      S_N_LOW:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_MRW;
          ma_nxt = rhtc_pkg::PATTERN_LOW_REG;
          op_nxt = trn_r[7:0];
          tmr_nxt = 32'(rhtc_pkg::MRD_CYC - 1);
          state_nxt = S_N_HIGH;
        end
      S_N_HIGH:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_MRW;
          ma_nxt = rhtc_pkg::PATTERN_HIGH_REG;
          op_nxt = trn_r[15:8];
          tmr_nxt = 32'(rhtc_pkg::MRD_CYC - 1);
          state_nxt = S_N_ON;
        end
      S_N_ON:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_MRW;
          ma_nxt = rhtc_pkg::TRAINING_CTRL_REG;
          op_nxt = rhtc_pkg::TRN_ON_OP;
          tmr_nxt = 32'(rhtc_pkg::MRD_CYC + rhtc_pkg::SDO_CYC - 1);
          cnt_nxt = 8'h00;
          state_nxt = S_N_MPC;
        end
      S_N_MPC:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_MPC_RDC;
          state_nxt = S_N_CAS;
        end
      S_N_CAS:
      begin
        cv_nxt = 1'b1;
        cc_nxt = rhtc_pkg::CMD_CAS2;
        op_nxt = rhtc_pkg::OP_ZERO;
        tmr_nxt = 32'(rhtc_pkg::CCD_CYC - 2);
        cnt_nxt = cnt_r + 8'h01;
        state_nxt = (cnt_r == last) ? S_N_OFF : S_N_MPC;
      end
      S_N_OFF:
        if (go)
        begin
          cv_nxt = 1'b1;
          cc_nxt = rhtc_pkg::CMD_MRW;
          ma_nxt = rhtc_pkg::TRAINING_CTRL_REG;
          op_nxt = rhtc_pkg::OP_ZERO;
          tmr_nxt = 32'(rhtc_pkg::MRD_CYC + rhtc_pkg::SDO_CYC - 1);
          state_nxt = S_N_END;
        end
      S_N_END:
        if (go)
        begin
          flag_nxt[2] = 1'b1;
          state_nxt = S_IDLE;
        end
    endcase
    if (abt && trr_st)
    begin
      tmr_nxt = 32'(rhtc_pkg::RP_CYC - 1);
      cv_nxt = 1'b0;
      state_nxt = S_A_MRW;
    end
    refresh_hold_out = in_trr || in_ppr;
  end

  assign bank_hold_out = (hold_r != 16'h0000) || in_ppr;

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= S_IDLE;
      tmr_r <= 32'h0000_0000;
      hold_r <= 16'h0000;
      cnt_r <= 8'h00;
      bank_r <= 3'h0;
      row_r <= 16'h0000;
      caps_r <= 8'h00;
      res_r <= 8'h00;
      trn_r <= 24'h00_0000;
      flag_r <= 5'h00;
      cv_r <= 1'b0;
      cc_r <= 3'h0;
      op_r <= 8'h00;
      ma_r <= 6'h00;
      crow_r <= 16'h0000;
      rd_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      hold_r <= hold_nxt;
      cnt_r <= cnt_nxt;
      bank_r <= bank_nxt;
      row_r <= row_nxt;
      caps_r <= caps_nxt;
      res_r <= res_nxt;
      trn_r <= trn_nxt;
      flag_r <= flag_nxt;
      cv_r <= cv_nxt;
      cc_r <= cc_nxt;
      op_r <= op_nxt;
      ma_r <= ma_nxt;
      crow_r <= crow_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign rdata_out = rd_r;
  assign cmd_valid_out = cv_r;
  assign cmd_code_out = cc_r;
  assign cmd_bank_out = bank_r;
  assign cmd_row_out = crow_r;
  assign cmd_mr_addr_out = ma_r;
  assign cmd_op_out = op_r;
endmodule // rhtc_ctrl
`default_nettype wire

// [testbench/rhtc_properties.sv]
// Purpose: port checks of the host sequencer command timing
// Assumes: shortened repair counts handed on by the bind
// Notes: helper logic counts idle cycles between commands
`timescale 1ns/1ns
`default_nettype none
module rhtc_chk #(
  parameter int PROG_CYCLES = 20,
  parameter int SETTLE_CYCLES = 10
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic cmd_valid_out,
  input wire logic [2:0] cmd_code_out,
  input wire logic [2:0] cmd_bank_out,
  input wire logic [15:0] cmd_row_out,
  input wire logic [5:0] cmd_mr_addr_out,
  input wire logic [7:0] cmd_op_out,
  input wire logic refresh_hold_out,
  input wire logic bank_hold_out
);
  localparam int MRD = rhtc_pkg::MRD_CYC;
  localparam int RAS15 = rhtc_pkg::RAS15_CYC;
  localparam int RP = rhtc_pkg::RP_CYC;
  localparam int HOLDM = rhtc_pkg::HOLD_CYC - 1;
  localparam int HAMMERED_ROW = rhtc_pkg::MRD_CYC + rhtc_pkg::SDO_CYC;
  logic [31:0] gap_r, gap_nxt;
  logic rep_r, rep_nxt, v_act, v_pre, v_mrw, v_mpc;
  assign v_act = cmd_valid_out && cmd_code_out == rhtc_pkg::CMD_ACT;
  assign v_pre = cmd_valid_out && cmd_code_out == rhtc_pkg::CMD_PRE;
  assign v_mrw = cmd_valid_out && cmd_code_out == rhtc_pkg::CMD_MRW;
  assign v_mpc = cmd_valid_out && cmd_code_out == rhtc_pkg::CMD_MPC_RDC;
  always_comb
  begin
    gap_nxt = cmd_valid_out ? 32'h0 : gap_r + 32'h1;
    rep_nxt = rep_r;
    if (v_mrw && cmd_mr_addr_out == rhtc_pkg::REFRESH_REPAIR_REG)
      rep_nxt = cmd_op_out[4];
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      gap_r <= 32'h0;
      rep_r <= 1'b0;
    end
    else
    begin
      gap_r <= gap_nxt;
      rep_r <= rep_nxt;
    end
  end
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_trr_on;
    v_mrw && cmd_mr_addr_out == rhtc_pkg::ROW_HAMMER_CTRL_REG && cmd_op_out[7];
  endsequence
  sequence s_first_act;
    v_act && $rose(bank_hold_out);
  endsequence
  a_mpc_cas_pair: assert property (v_mpc |=> cmd_valid_out && cmd_code_out == 3'h5)
    else $error("calibration command without cas2");
  a_cas_ops_low: assert property (cmd_valid_out && cmd_code_out == 3'h5 |-> cmd_op_out == 8'h00)
    else $error("cas2 operands not low");
  a_trr_bank_field: assert property (s_trr_on |-> cmd_op_out[6:4] == cmd_bank_out)
    else $error("bank field differs from bank");
  a_trr_first_act: assert property (s_trr_on |-> ##MRD v_act)
    else $error("no activate one mode delay after enable");
  a_first_pre_gap: assert property (s_first_act |-> ##RAS15 v_pre)
    else $error("first precharge mistimed");
  a_bank_hold_span: assert property (s_first_act |-> bank_hold_out ##HOLDM bank_hold_out ##1 !bank_hold_out)
    else $error("bank hold span wrong");
  a_act_spacing: assert property (v_act |-> $past(v_pre, RP) || $past(v_mrw, MRD))
    else $error("activate spacing wrong");
  a_repair_quiet: assert property (v_pre && rep_r |-> gap_r == PROG_CYCLES - 1)
    else $error("repair program time wrong");
  a_repair_exit: assert property (v_mrw && rep_r && cmd_op_out == 8'h00 |-> gap_r == rhtc_pkg::EXIT_CYC - 1)
    else $error("repair exit time wrong");
  a_trn_first_mpc: assert property (v_mrw && cmd_op_out == rhtc_pkg::TRN_ON_OP && cmd_mr_addr_out == 6'h0D |-> ##HAMMERED_ROW v_mpc)
    else $error("first calibration mistimed");
endmodule // rhtc_chk
bind rhtc_ctrl rhtc_chk #(.PROG_CYCLES(PROG_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cmd_valid_out(cmd_valid_out),
  .cmd_code_out(cmd_code_out), .cmd_bank_out(cmd_bank_out), .cmd_row_out(cmd_row_out),
  .cmd_mr_addr_out(cmd_mr_addr_out), .cmd_op_out(cmd_op_out),
  .refresh_hold_out(refresh_hold_out), .bank_hold_out(bank_hold_out));
`default_nettype wire

// [testbench/rhtc_dev_model.sv]
// Purpose: behavioural device side, tracks mode state from the command stream
// Assumes: one command per clock
// Notes: burst holds the last training pattern, low byte first
`timescale 1ns/1ns
`default_nettype none
module rhtc_dev_model #(
  parameter logic [15:0] INV_MASK = 16'h0000
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_code_in,
  input wire logic [5:0] cmd_mr_addr_in,
  input wire logic [7:0] cmd_op_in,
  output logic trr_on_out,
  output logic trn_on_out,
  output logic rep_on_out,
  output logic [1:0] pre_cnt_out,
  output logic [15:0] burst_out
);
  logic [7:0] lo_r, hi_r;
  int wait_r;
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      {trr_on_out, trn_on_out, rep_on_out, pre_cnt_out, burst_out, lo_r, hi_r} = '0;
      wait_r = 0;
    end
    else
    begin
      if (wait_r == 1)
        trr_on_out = 1'b0;
      if (wait_r > 0)
        wait_r--;
      // activates leave the internal refresh count alone
      if (cmd_valid_in && cmd_code_in == rhtc_pkg::CMD_MRW)
      begin
        pre_cnt_out = 2'h0;
        case (cmd_mr_addr_in)
          rhtc_pkg::ROW_HAMMER_CTRL_REG: trr_on_out = cmd_op_in[7];
          rhtc_pkg::TRAINING_CTRL_REG: trn_on_out = cmd_op_in[1];
          rhtc_pkg::REFRESH_REPAIR_REG: rep_on_out = cmd_op_in[4];
          rhtc_pkg::PATTERN_LOW_REG: lo_r = cmd_op_in;
          rhtc_pkg::PATTERN_HIGH_REG: hi_r = cmd_op_in;
          default: ;
        endcase
      end
      else if (cmd_valid_in && trr_on_out && cmd_code_in inside {3'h2, 3'h3})
      begin
        pre_cnt_out++;
        if (pre_cnt_out == 2'h3)
          wait_r = rhtc_pkg::RP_CYC + rhtc_pkg::MRD_CYC;
      end
      else if (cmd_valid_in && trn_on_out && cmd_code_in == rhtc_pkg::CMD_CAS2)
        burst_out = {lo_r, hi_r} ^ INV_MASK;
    end
  end
endmodule // rhtc_dev_model
`default_nettype wire

// [testbench/test_dram_row_repair_and_training_modes.sv]
// Purpose: self-checking bench for the host sequencer
// Assumes: repair counts shortened to 20 and 10 cycles
// Notes: commands are compared in order against a queue of notes
`timescale 1ns/1ns
`default_nettype none
module test_dram_row_repair_and_training_modes;
  typedef struct packed {logic [2:0] c; logic [5:0] m; logic [7:0] o, om; logic [15:0] r;} rhtc_exp_type;
  logic ref_clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, rd_late = 1'b0;
  logic [7:0] addr_in = 8'h00, lo, hi;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  logic cmd_valid_out, refresh_hold_out, bank_hold_out, trr_on, trn_on, rep_on;
  logic [2:0] cmd_code_out, cmd_bank_out, bank;
  logic [15:0] cmd_row_out, row, burst;
  logic [5:0] cmd_mr_addr_out;
  logic [7:0] cmd_op_out;
  logic [1:0] pre_cnt;
  int bad_count = 0, compares = 0, cyc = 0, n;
  rhtc_exp_type exp_q[$], e;
  logic [31:0] rd_q[$];
  rhtc_ctrl #(.PROG_CYCLES(20), .SETTLE_CYCLES(10)) u_dut (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .cmd_valid_out(cmd_valid_out), .cmd_code_out(cmd_code_out),
    .cmd_bank_out(cmd_bank_out), .cmd_row_out(cmd_row_out), .cmd_mr_addr_out(cmd_mr_addr_out),
    .cmd_op_out(cmd_op_out), .refresh_hold_out(refresh_hold_out), .bank_hold_out(bank_hold_out));
  rhtc_dev_model u_dev (.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_out),
    .cmd_code_in(cmd_code_out), .cmd_mr_addr_in(cmd_mr_addr_out), .cmd_op_in(cmd_op_out),
    .trr_on_out(trr_on), .trn_on_out(trn_on), .rep_on_out(rep_on), .pre_cnt_out(pre_cnt),
    .burst_out(burst));
  initial
    forever #2 ref_clk_in = ~ref_clk_in;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    rd_q.push_back(want);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
  endtask
  task automatic ex(input logic [2:0] c, input logic [5:0] m, input logic [7:0] o, om);
    exp_q.push_back({c, m, o, om, row});
  endtask
  task automatic push_trr();
    ex(rhtc_pkg::CMD_MRW, 6'h18, {1'b1, bank, 4'h4}, 8'hFF);
    repeat (3)
    begin
      ex(rhtc_pkg::CMD_ACT, 6'h00, 8'h00, 8'h00);
      ex(rhtc_pkg::CMD_PRE, 6'h00, 8'h00, 8'h00);
    end
  endtask
  task automatic drain(input logic [31:0] stat);
    n = 0;
    while (exp_q.size() != 0 && n < 400)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    repeat (20) @(posedge ref_clk_in);
    check("pending cmds", exp_q.size(), 32'h0);
    check("hold idle", {30'h0, refresh_hold_out, bank_hold_out}, 32'h0);
    rd(rhtc_pkg::STAT_OFS, stat);
    // the reset-needed flag is left standing
    wr(rhtc_pkg::STAT_OFS, stat & 32'h1D);
  endtask
  // watcher: read data and commands against the oldest note
  always @(posedge ref_clk_in)
    rd_late <= rd_in;
  always @(negedge ref_clk_in)
  begin
    if (rd_late)
      check("rdata", rdata_out, rd_q.pop_front());
    if (cmd_valid_out && exp_q.size() == 0)
      check("extra cmd", {29'h0, cmd_code_out}, 32'hFFFFFFFF);
    else if (cmd_valid_out)
    begin
      e = exp_q.pop_front();
      check("cmd code", {29'h0, cmd_code_out}, {29'h0, e.c});
      check("op", {24'h0, cmd_op_out & e.om}, {24'h0, e.o & e.om});
      if (e.c == rhtc_pkg::CMD_MRW)
        check("mr addr", {26'h0, cmd_mr_addr_out}, {26'h0, e.m});
      if (e.c == rhtc_pkg::CMD_ACT)
      begin
        check("row", {16'h0, cmd_row_out}, {16'h0, e.r});
        check("refresh hold", {31'h0, refresh_hold_out}, 32'h1);
      end
    end
  end
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      final_report();
    end
  end
  initial
  begin
    void'($urandom(87411));
    {bank, row} = 19'($urandom());
    {lo, hi} = 16'($urandom());
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd(rhtc_pkg::STAT_OFS, 32'h0);
    rd(8'h40, 32'h0);
    wr(rhtc_pkg::TRR_CFG_OFS, {row, 13'h0, bank});
    wr(rhtc_pkg::CAPS_OFS, {16'h0, 8'h01 << bank, 8'h08});
    wr(rhtc_pkg::CTRL_OFS, 32'h1);
    drain(32'h8);
    $display("test skip done");
    wr(rhtc_pkg::CAPS_OFS, {16'h0, 8'h01 << bank, 8'h04});
    push_trr();
    wr(rhtc_pkg::CTRL_OFS, 32'h1);
    drain(32'h1);
    check("trr self clear", {31'h0, trr_on}, 32'h0);
    check("pre count", {30'h0, pre_cnt}, 32'h3);
    $display("test trr done");
    ex(rhtc_pkg::CMD_MRW, 6'h18, {1'b1, bank, 4'h4}, 8'hFF);
    ex(rhtc_pkg::CMD_ACT, 6'h00, 8'h00, 8'h00);
    ex(rhtc_pkg::CMD_PRE, 6'h00, 8'h00, 8'h00);
    ex(rhtc_pkg::CMD_MRW, 6'h18, 8'h00, 8'h80);
    repeat (3) ex(rhtc_pkg::CMD_PRE, 6'h00, 8'h00, 8'h00);
    push_trr();
    wr(rhtc_pkg::CTRL_OFS, 32'h1);
    n = 0;
    while (!(cmd_valid_out && cmd_code_out == rhtc_pkg::CMD_PRE) && n < 100)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    wr(rhtc_pkg::CTRL_OFS, 32'h8);
    drain(32'h1);
    check("rerun pre count", {30'h0, pre_cnt}, 32'h3);
    $display("test abort done");
    wr(rhtc_pkg::TRN_CFG_OFS, {16'h02, hi, lo});
    ex(rhtc_pkg::CMD_MRW, 6'h20, lo, 8'hFF);
    ex(rhtc_pkg::CMD_MRW, 6'h28, hi, 8'hFF);
    ex(rhtc_pkg::CMD_MRW, 6'h0D, 8'h02, 8'hFF);
    repeat (2)
    begin
      ex(rhtc_pkg::CMD_MPC_RDC, 6'h00, 8'h00, 8'h00);
      ex(rhtc_pkg::CMD_CAS2, 6'h00, 8'h00, 8'hFF);
    end
    ex(rhtc_pkg::CMD_MRW, 6'h0D, 8'h00, 8'hFF);
    wr(rhtc_pkg::CTRL_OFS, 32'h4);
    drain(32'h4);
    check("burst", {16'h0, burst}, {16'h0, lo, hi});
    check("training off", {31'h0, trn_on}, 32'h0);
    $display("test training done");
    wr(rhtc_pkg::CTRL_OFS, {~rhtc_pkg::PPR_KEY, 24'h2});
    drain(32'h10);
    ex(rhtc_pkg::CMD_PREA, 6'h00, 8'h00, 8'h00);
    ex(rhtc_pkg::CMD_MRW, 6'h04, 8'h10, 8'hFF);
    ex(rhtc_pkg::CMD_ACT, 6'h00, 8'h00, 8'h00);
    ex(rhtc_pkg::CMD_PRE, 6'h00, 8'h00, 8'h00);
    ex(rhtc_pkg::CMD_MRW, 6'h04, 8'h00, 8'hFF);
    wr(rhtc_pkg::CTRL_OFS, {rhtc_pkg::PPR_KEY, 24'h2});
    drain(32'h2);
    check("repair off", {31'h0, rep_on}, 32'h0);
    wr(rhtc_pkg::CTRL_OFS, {rhtc_pkg::PPR_KEY, 24'h2});
    drain(32'h12);
    $display("test repair done");
    final_report();
  end
endmodule // test_dram_row_repair_and_training_modes
`default_nettype wire
